// [rtl/comparator_result_irq_mask.sv]
// Contract
// RQ1 - Result register shows each comparator output
// RQ2 - Bit is one when positive not below
// RQ3 - Channel inputs chosen by own select fields
// RQ4 - Software ignores reserved upper bits
// RQ5 - Enable write of one unmasks channel
// RQ6 - Disable write of one masks channel
// RQ7 - Result, enable, disable bits reset zero
// RQ8 - Mask state reads one when unmasked
// RQ9 - Raw flag shows asserting condition
// RQ10 - Pending flag set unmasked, write-one clears
// RQ11 - Zero writes no effect; IRQ ORs unmasked
//
// The APB slave port was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "cmp_irq_consts.svh"

module comparator_result_irq_mask
  import cmp_irq_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              CORE_CLK,
  input  wire logic              NRST,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [31:0]       PWDATA,
  output var  logic [31:0]       PRDATA,
  output var  logic              PREADY,
  output var  logic              PSLVERR,
  input  wire logic [3:0]        CMP_IN,
  output var  logic [11:0]       POS_SEL,
  output var  logic [11:0]       NEG_SEL,
  output var  logic              IRQ
);

  // ****************************************************************
  // Comparator output synchroniser
  // ****************************************************************
  chan_vec_t sync1_ff;
  chan_vec_t res_ff;
  chan_vec_t res_prev_ff;

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      sync1_ff    <= `CHAN_RST;
      res_ff      <= `CHAN_RST;
      res_prev_ff <= `CHAN_RST;
    end else begin
      sync1_ff    <= CMP_IN;
      res_ff      <= sync1_ff;                                   // RQ2
      res_prev_ff <= res_ff;
    end
  end

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [11:0]       ofs);
    hit = (a == ofs[ADDR_W-1:0]);
  endfunction : hit

  logic       pready_ff;
  logic       setup;
  logic       wr_en;
  logic       wr_ier;
  logic       wr_idr;
  logic       wr_clr;
  logic [3:0] wr_cfg;
  logic       mapped;

  assign setup  = PSEL & ~PENABLE & ~pready_ff;
  assign wr_en  = PSEL & PENABLE & PWRITE & pready_ff;
  assign wr_ier = wr_en & hit(PADDR, `OFS_IRQ_ENABLE);
  assign wr_idr = wr_en & hit(PADDR, `OFS_IRQ_DISABLE);
  assign wr_clr = wr_en & hit(PADDR, `OFS_PENDING_FLAG);

  genvar g;
  generate
    for (g = 0; g < `CHAN_N; g++) begin : g_cfg_dec
      localparam logic [11:0] CFG_OFS =
        12'(`OFS_CH0_CONFIG + g * `OFS_CONFIG_STEP);
      assign wr_cfg[g] = wr_en & hit(PADDR, CFG_OFS);
    end
  endgenerate

  assign mapped = hit(PADDR, `OFS_CH0_CONFIG) | hit(PADDR, `OFS_CH1_CONFIG)
                | hit(PADDR, `OFS_CH2_CONFIG) | hit(PADDR, `OFS_CH3_CONFIG)
                | hit(PADDR, `OFS_RESULT)     | hit(PADDR, `OFS_IRQ_ENABLE)
                | hit(PADDR, `OFS_IRQ_DISABLE) | hit(PADDR, `OFS_MASK_STATE)
                | hit(PADDR, `OFS_RAW_FLAG)   | hit(PADDR, `OFS_PENDING_FLAG);

  // ****************************************************************
  // Channel input selection
  // ****************************************************************
  logic [11:0] pos_ff;
  logic [11:0] neg_ff;
  logic [11:0] nxt_pos;
  logic [11:0] nxt_neg;

  generate
    for (g = 0; g < `CHAN_N; g++) begin : g_sel
      assign nxt_pos[g*3 +: 3] = wr_cfg[g] ?                       // RQ3
        PWDATA[`POS_SEL_LSB +: `SEL_W] : pos_ff[g*3 +: 3];
      assign nxt_neg[g*3 +: 3] = wr_cfg[g] ?                       // RQ3
        PWDATA[`NEG_SEL_LSB +: `SEL_W] : neg_ff[g*3 +: 3];
    end
  endgenerate

  // ****************************************************************
  // Mask, pending flags and interrupt
  // ****************************************************************
  chan_vec_t mask_ff;
  chan_vec_t pend_ff;
  chan_vec_t nxt_mask;
  chan_vec_t nxt_pend;
  chan_vec_t rise;
  logic      irq_ff;

  assign rise     = res_ff & ~res_prev_ff;                         // RQ9
  assign nxt_mask = (mask_ff | ({4{wr_ier}} & PWDATA[3:0]))       // RQ5 RQ11
                  & ~({4{wr_idr}} & PWDATA[3:0]);                  // RQ6
  // Set wins over a clear in the same cycle
  assign nxt_pend = (pend_ff & ~({4{wr_clr}} & PWDATA[3:0]))      // RQ10
                  | (rise & mask_ff);

  // ****************************************************************
  // Read data
  // ****************************************************************
  word_t rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    for (int i = 0; i < `CHAN_N; i++) begin
      if (hit(PADDR, 12'(`OFS_CH0_CONFIG + i * `OFS_CONFIG_STEP))) begin
        rd_mux[`POS_SEL_LSB +: `SEL_W] = pos_ff[i*3 +: 3];
        rd_mux[`NEG_SEL_LSB +: `SEL_W] = neg_ff[i*3 +: 3];
      end
    end
    if (hit(PADDR, `OFS_RESULT))       rd_mux[3:0] = res_ff;      // RQ1
    if (hit(PADDR, `OFS_MASK_STATE))   rd_mux[3:0] = mask_ff;     // RQ8
    if (hit(PADDR, `OFS_RAW_FLAG))     rd_mux[3:0] = res_ff;      // RQ9
    if (hit(PADDR, `OFS_PENDING_FLAG)) rd_mux[3:0] = pend_ff;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      pready_ff <= 1'b0;
      PRDATA    <= 32'h0000_0000;
      PSLVERR   <= 1'b0;
      pos_ff    <= {`CHAN_N{`SEL_RST}};
      neg_ff    <= {`CHAN_N{`SEL_RST}};
      mask_ff   <= `CHAN_RST;                                      // RQ7
      pend_ff   <= `CHAN_RST;
      irq_ff    <= 1'b0;
    end else begin
      pready_ff <= setup;
      PRDATA    <= (setup & ~PWRITE) ? rd_mux : 32'h0000_0000;
      PSLVERR   <= setup & ~mapped;
      pos_ff    <= nxt_pos;
      neg_ff    <= nxt_neg;
      mask_ff   <= nxt_mask;
      pend_ff   <= nxt_pend;
      irq_ff    <= |(pend_ff & mask_ff);                           // RQ11
    end
  end

  assign PREADY  = pready_ff;
  assign POS_SEL = pos_ff;
  assign NEG_SEL = neg_ff;
  assign IRQ     = irq_ff;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge CORE_CLK);
  endclocking

  default disable iff (!NRST);

  sequence s_access(logic [11:0] ofs, logic wr);
    PSEL && PENABLE && PREADY && PWRITE == wr
      && PADDR == ofs[ADDR_W-1:0];
  endsequence

  // Unmasked pending bit first, request one cycle later
  sequence s_irq_follow;
    (|(pend_ff & mask_ff)) ##1 IRQ;
  endsequence

  a_result_read: assert property ( // RQ1
    s_access(`OFS_RESULT, 1'b0) |-> PRDATA == {28'h0, $past(res_ff)})
    else $error("result read mismatch");

  // Only once both stages have left reset
  a_result_sync: assert property ( // RQ2
    $past(NRST, 2) |-> res_ff == $past(CMP_IN, 2))
    else $error("result not two cycles behind input");

  a_select_load: assert property ( // RQ3
    s_access(`OFS_CH0_CONFIG, 1'b1) |=>
      POS_SEL[2:0] == $past(PWDATA[2:0]) && NEG_SEL[2:0] == $past(PWDATA[6:4]))
    else $error("channel select not loaded");

  a_enable_set: assert property ( // RQ5
    s_access(`OFS_IRQ_ENABLE, 1'b1) |=>
      (mask_ff & $past(PWDATA[3:0])) == $past(PWDATA[3:0]))
    else $error("enable write did not unmask");

  a_disable_clr: assert property ( // RQ6
    s_access(`OFS_IRQ_DISABLE, 1'b1) |=>
      (mask_ff & $past(PWDATA[3:0])) == 4'h0)
    else $error("disable write did not mask");

  a_reset_zero: assert property ( // RQ7
    $rose(NRST) |-> mask_ff == 4'h0 && pend_ff == 4'h0 && !IRQ)
    else $error("state not zero after reset");

  a_mask_read: assert property ( // RQ8
    s_access(`OFS_MASK_STATE, 1'b0) |-> PRDATA == {28'h0, $past(mask_ff)})
    else $error("mask read mismatch");

  a_raw_read: assert property ( // RQ9
    s_access(`OFS_RAW_FLAG, 1'b0) |-> PRDATA == {28'h0, $past(res_ff)})
    else $error("raw read mismatch");

  // A disable in the event cycle may legally drop the request
  a_pend_set: assert property ( // RQ10
    (|(rise & mask_ff)) && !wr_idr |=> s_irq_follow)
    else $error("pending flag or irq missing");

  // Cleared bits stay clear unless a new event sets them
  a_pend_clear: assert property ( // RQ10
    wr_clr |=> (pend_ff & $past(PWDATA[3:0] & ~(rise & mask_ff))) == 4'h0)
    else $error("pending flag not cleared");

  a_mask_hold: assert property ( // RQ11
    !wr_ier && !wr_idr |=> $stable(mask_ff))
    else $error("mask changed without write");

endmodule : comparator_result_irq_mask

`default_nettype wire

// [rtl/cmp_irq_consts.svh]
`ifndef CMP_IRQ_CONSTS_SVH
`define CMP_IRQ_CONSTS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_CH0_CONFIG   12'h004
`define OFS_CH1_CONFIG   12'h00C
`define OFS_CH2_CONFIG   12'h014
`define OFS_CH3_CONFIG   12'h01C
`define OFS_RESULT       12'h024
`define OFS_IRQ_ENABLE   12'h028
`define OFS_IRQ_DISABLE  12'h02C
`define OFS_MASK_STATE   12'h030
`define OFS_RAW_FLAG     12'h034
`define OFS_PENDING_FLAG 12'h038
`define OFS_CONFIG_STEP  12'h008

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define POS_SEL_LSB      0
`define NEG_SEL_LSB      4
`define SEL_W            3
`define CHAN_N           4
`define CHAN_RST         4'h0
`define SEL_RST          3'h0

`endif

// [rtl/cmp_irq_pkg.sv]
package cmp_irq_pkg;
  typedef logic [3:0]  chan_vec_t;
  typedef logic [2:0]  sel_t;
  typedef logic [31:0] word_t;
endpackage : cmp_irq_pkg

// [bench/comparator_result_irq_mask_tb.sv]
`timescale 1ns/10ps
`default_nettype none

module comparator_result_irq_mask_tb
  import cmp_irq_pkg::*;
;
  logic        core_clk;
  logic        nrst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  word_t       pwdata;
  word_t       prdata;
  logic        pready;
  logic        pslverr;
  chan_vec_t   cmp_in;
  logic [11:0] pos_sel;
  logic [11:0] neg_sel;
  logic        irq;
  int          failures;
  int          num_checks;
  word_t       rdat;
  logic        err;

  comparator_result_irq_mask i_comparator_result_irq_mask (
    .CORE_CLK (core_clk),
    .NRST     (nrst),
    .PSEL     (psel),
    .PENABLE  (penable),
    .PWRITE   (pwrite),
    .PADDR    (paddr),
    .PWDATA   (pwdata),
    .PRDATA   (prdata),
    .PREADY   (pready),
    .PSLVERR  (pslverr),
    .CMP_IN   (cmp_in),
    .POS_SEL  (pos_sel),
    .NEG_SEL  (neg_sel),
    .IRQ      (irq)
  );

  initial core_clk = 1'b0;
  always #50 core_clk = ~core_clk;

  // ************************************************************
  // Bus and compare tasks
  // ************************************************************
  task chk(input word_t got, input word_t exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%08h exp=%08h", $time, got, exp);
    end
  endtask : chk

  // Holds the request until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input word_t d);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
    end
    rdat = prdata;
    err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb

  task wr(input logic [11:0] a, input word_t d);
    apb(1'b1, a, d);
  endtask : wr

  task rd(input logic [11:0] a, input word_t exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask : rd

  task settle();
    repeat (4) @(posedge core_clk);
  endtask : settle

  task end_of_test();
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test

  // ************************************************************
  // Test sequence
  // ************************************************************
  initial begin
    nrst       = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 12'h000;
    pwdata     = 32'h0000_0000;
    cmp_in     = 4'h0;
    failures   = 0;
    num_checks = 0;
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    rd(12'h024, 32'h0);
    rd(12'h030, 32'h0);
    rd(12'h028, 32'h0);
    rd(12'h02C, 32'h0);
    cmp_in <= 4'hA;
    settle();
    rd(12'h024, 32'h0000000A);
    rd(12'h034, 32'h0000000A);
    cmp_in <= 4'h5;
    settle();
    rd(12'h024, 32'h00000005);
    for (int i = 0; i < 4; i++) begin
      wr(12'h004 + 12'(8 * i), 32'((i << 4) | (7 - i)));
    end
    chk({20'h0, pos_sel}, 32'h00000977);
    chk({20'h0, neg_sel}, 32'h00000688);
    wr(12'h028, 32'h00000005);
    rd(12'h030, 32'h00000005);
    wr(12'h028, 32'h0);
    rd(12'h030, 32'h00000005);
    wr(12'h02C, 32'h00000001);
    rd(12'h030, 32'h00000004);
    wr(12'h02C, 32'h0);
    wr(12'h030, 32'h0000000F);
    rd(12'h030, 32'h00000004);
    cmp_in <= 4'h0;
    settle();
    rd(12'h038, 32'h0);
    cmp_in <= 4'h5;
    settle();
    // Request trails the pending bit by one cycle
    rd(12'h038, 32'h00000004);
    chk({31'h0, irq}, 32'h1);
    wr(12'h038, 32'h00000004);
    repeat (3) @(posedge core_clk);
    chk({31'h0, irq}, 32'h0);
    rd(12'h038, 32'h0);
    apb(1'b0, 12'h040, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rdat, 32'h0);
    // Second reset in mid-run clears mask and selects
    nrst <= 1'b0;
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    chk({20'h0, pos_sel}, 32'h0);
    rd(12'h030, 32'h0);
    end_of_test();
  end

  initial begin
    repeat (3000) @(posedge core_clk);
    failures++;
    end_of_test();
  end

endmodule : comparator_result_irq_mask_tb

`default_nettype wire
